// ---- host_config_eeprom_regs.sv ----
/*
 * banked host configuration registers: base and station address, burst
 * length, on-chip bus speed, eeprom pin access and memory self-test flags.
 * assumes a host port on the reference clock doing 16-bit word accesses
 * with byte enables, and an eeprom plus strap arriving from pins.
 */
`timescale 1ns/100ps
`default_nettype none
`include "host_cfg_consts.svh"

module host_config_eeprom_regs
   import host_cfg_pkg::*;
#(
   parameter int EE_HALF_CYC = `EE_SK_HALF_CYC
)
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   // host register port
   input wire logic [3:0] i_host_addr,
   input wire logic i_host_rd,
   input wire logic i_host_wr,
   input wire logic [1:0] i_host_be,
   input wire logic [15:0] i_host_wdata,
   output logic [15:0] o_host_rdata,
   output logic o_host_rdata_valid,
   // eeprom pins and strap
   input wire logic i_eeprom_present_pin,
   input wire logic i_eeprom_serial_in,
   output logic o_eeprom_chip_sel,
   output logic o_eeprom_serial_clk,
   output logic o_eeprom_serial_out,
   // self-test results
   input wire logic i_tx_selftest_done,
   input wire logic i_tx_selftest_failed,
   input wire logic i_rx_selftest_done,
   input wire logic i_rx_selftest_failed,
   // configuration to the rest of the chip
   output logic [15:0] o_base_addr,
   output logic [47:0] o_station_addr,
   output logic [2:0] o_burst_len_field,
   output logic [4:0] o_burst_beats,
   output logic [1:0] o_bus_speed_field,
   output logic o_bus_tick,
   output logic o_config_busy
);

   // pin mux plus input synchroniser eat three cycles of each clock phase
   if (EE_HALF_CYC < 4 || EE_HALF_CYC > 255) begin : g_half_check
      $error("host_config_eeprom_regs: EE_HALF_CYC out of range");
   end

   typedef struct packed {
      top_state_t st;
      logic [1:0] settle;
      logic pres_s1;
      logic pres_s2;
      logic di_s1;
      logic di_s2;
      logic [5:0] bank;
      logic [10:0] base;
      logic [2:0] burst;
      logic [4:0] beats;
      logic [15:0] stn_low;
      logic [15:0] stn_mid;
      logic [15:0] stn_high;
      logic [1:0] speed;
      logic sw_en;
      logic [2:0] pins;
      logic [2:0] pin_q;
      logic [15:0] rdata;
      logic rvalid;
   } top_reg_t;

   localparam logic [15:0] BASE_RST = `BASE_ADDR_RESET;
   localparam top_reg_t TOP_RESET = '{
      st: TOP_SETTLE,
      bank: `BANK_SEL_RESET,
      base: BASE_RST[15:`BASE_LSB],
      burst: `BURST_RESET,
      beats: 5'h01,
      speed: `SPEED_RESET,
      default: '0
   };

   top_reg_t r, n;
   logic ld_start;
   logic ld_done;
   logic ld_valid;
   logic [2:0] ld_idx;
   logic [15:0] ld_data;
   logic ld_cs;
   logic ld_sk;
   logic ld_do;
   logic [3:0] wofs;
   logic [15:0] wm;
   logic [15:0] rd;

   ////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                         input logic [1:0] be);
      merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction

   // reserved codes fall back to single transfers
   function automatic logic [4:0] beats_of(input logic [2:0] code);
      case (code)
         `BURST_4: beats_of = 5'h04;
         `BURST_8: beats_of = 5'h08;
         `BURST_16: beats_of = 5'h10;
         default: beats_of = 5'h01;
      endcase
   endfunction

   // byte lane bit 0 is ignored: every register is a whole word
   assign wofs = {i_host_addr[3:1], 1'b0};

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      n = r;
      n.rvalid = 1'b0;
      ld_start = 1'b0;
      wm = 16'h0000;
      rd = 16'h0000;

      n.pres_s1 = i_eeprom_present_pin;
      n.pres_s2 = r.pres_s1;
      n.di_s1 = i_eeprom_serial_in;
      n.di_s2 = r.di_s1;

      // strap is judged only once the synchroniser has filled after release
      unique case (r.st)
         TOP_SETTLE: begin
            if (r.settle == `STRAP_SETTLE) begin
               if (r.pres_s2) begin
                  ld_start = 1'b1;
                  n.st = TOP_LOAD;
               end else begin
                  n.st = TOP_READY;
               end
            end else begin
               n.settle = r.settle + 2'h1;
            end
         end
         TOP_LOAD: begin
            if (ld_done) begin
               n.st = TOP_READY;
            end
         end
         TOP_READY: begin
         end
      endcase

      // host writes; nothing here ever starts an eeprom write cycle
      if (i_host_wr) begin
         if (wofs == `BANK_SEL_OFS) begin
            wm = merge({10'h000, r.bank}, i_host_wdata, i_host_be);
            n.bank = wm[5:0];
         end else begin
            case (r.bank)
               `BANK_0: begin
                  case (wofs)
                     `OFS_BASE_ADDR: begin
                        wm = merge({r.base, 5'h00}, i_host_wdata, i_host_be);
                        n.base = wm[15:`BASE_LSB];
                     end
                     `OFS_BURST_CTRL: begin
                        wm = merge({1'b0, r.burst, 12'h000}, i_host_wdata, i_host_be);
                        n.burst = wm[`BURST_MSB:`BURST_LSB];
                     end
                     default: begin
                     end
                  endcase
               end
               `BANK_2: begin
                  case (wofs)
                     `OFS_STN_LOW: n.stn_low = merge(r.stn_low, i_host_wdata, i_host_be);
                     `OFS_STN_MID: n.stn_mid = merge(r.stn_mid, i_host_wdata, i_host_be);
                     `OFS_STN_HIGH: n.stn_high = merge(r.stn_high, i_host_wdata, i_host_be);
                     default: begin
                     end
                  endcase
               end
               `BANK_3: begin
                  case (wofs)
                     `OFS_BUS_SPEED: begin
                        wm = merge({14'h0000, r.speed}, i_host_wdata, i_host_be);
                        n.speed = wm[1:0];
                     end
                     `OFS_EE_CTRL: begin
                        wm = merge({11'h000, r.sw_en, 1'b0, r.pins}, i_host_wdata, i_host_be);
                        n.sw_en = wm[`EE_SW_EN_BIT];
                        n.pins = wm[2:0];
                     end
                     default: begin
                     end
                  endcase
               end
               default: begin
               end
            endcase
         end
      end

      // words arriving from the eeprom overwrite a racing host write
      if (ld_valid) begin
         case (ld_idx)
            `EE_WORD_BASE: n.base = ld_data[15:`BASE_LSB];
            `EE_WORD_STN_LOW: n.stn_low = ld_data;
            `EE_WORD_STN_MID: n.stn_mid = ld_data;
            `EE_WORD_STN_HIGH: n.stn_high = ld_data;
            `EE_WORD_CONFIG: n.speed = ld_data[`EE_CFG_SPEED_BIT] ? `SPEED_25 : `SPEED_125;
            default: begin
            end
         endcase
      end

      n.beats = beats_of(n.burst);

      // pin owner; control bits are held but kept off the pins while access is off
      n.pin_q = r.sw_en ? r.pins : {ld_do, ld_sk, ld_cs};

      // read path
      if (i_host_rd) begin
         if (wofs == `BANK_SEL_OFS) begin
            rd = {10'h000, r.bank};
         end else begin
            case (r.bank)
               `BANK_0: begin
                  case (wofs)
                     `OFS_BASE_ADDR: rd = {r.base, 5'h00};
                     `OFS_BURST_CTRL: rd = {1'b0, r.burst, 12'h000};
                     default: rd = 16'h0000;
                  endcase
               end
               `BANK_2: begin
                  case (wofs)
                     `OFS_STN_LOW: rd = r.stn_low;
                     `OFS_STN_MID: rd = r.stn_mid;
                     `OFS_STN_HIGH: rd = r.stn_high;
                     default: rd = 16'h0000;
                  endcase
               end
               `BANK_3: begin
                  case (wofs)
                     `OFS_BUS_SPEED: rd = {14'h0000, r.speed};
                     `OFS_EE_CTRL: begin
                        rd = {11'h000, r.sw_en, 1'b0, r.pins};
                        rd[`EE_DI_BIT] = r.di_s2;
                     end
                     `OFS_SELFTEST: begin
                        rd[`ST_TX_DONE_BIT] = i_tx_selftest_done;
                        rd[`ST_TX_FAIL_BIT] = i_tx_selftest_failed;
                        rd[`ST_RX_DONE_BIT] = i_rx_selftest_done;
                        rd[`ST_RX_FAIL_BIT] = i_rx_selftest_failed;
                     end
                     default: rd = 16'h0000;
                  endcase
               end
               default: rd = 16'h0000;
            endcase
         end
         n.rdata = rd;
         n.rvalid = 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         r <= TOP_RESET;
      end else begin
         r <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // submodules

   eeprom_loader #(
      .HALF_CYC(EE_HALF_CYC)
   ) u_loader (
      .i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n),
      .i_start(ld_start),
      .o_done(ld_done),
      .o_word_valid(ld_valid),
      .o_word_idx(ld_idx),
      .o_word_data(ld_data),
      .i_serial_in(r.di_s2),
      .o_chip_sel(ld_cs),
      .o_serial_clk(ld_sk),
      .o_serial_out(ld_do)
   );

   bus_speed_divider u_speed (
      .i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n),
      .i_speed(r.speed),
      .o_tick(o_bus_tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign o_host_rdata = r.rdata;
   assign o_host_rdata_valid = r.rvalid;
   assign o_eeprom_serial_out = r.pin_q[2];
   assign o_eeprom_serial_clk = r.pin_q[1];
   assign o_eeprom_chip_sel = r.pin_q[0];
   assign o_base_addr = {r.base, 5'h00};
   assign o_station_addr = {r.stn_high, r.stn_mid, r.stn_low};
   assign o_burst_len_field = r.burst;
   assign o_burst_beats = r.beats;
   assign o_bus_speed_field = r.speed;
   assign o_config_busy = (r.st != TOP_READY);

endmodule
`default_nettype wire

// ---- host_cfg_consts.svh ----
/*
 * offsets, field positions, reset values and timing counts of the host
 * configuration register bank and its eeprom loader.
 * assumes a 16-bit banked host port and a 50 MHz reference clock.
 */
`ifndef HOST_CFG_CONSTS_SVH
`define HOST_CFG_CONSTS_SVH

// bank numbers and word offsets inside a bank
`define BANK_SEL_OFS 4'hE
`define BANK_0 6'h00
`define BANK_1 6'h01
`define BANK_2 6'h02
`define BANK_3 6'h03
`define OFS_BASE_ADDR 4'h0
`define OFS_BURST_CTRL 4'h8
`define OFS_STN_LOW 4'h0
`define OFS_STN_MID 4'h2
`define OFS_STN_HIGH 4'h4
`define OFS_BUS_SPEED 4'h0
`define OFS_EE_CTRL 4'h2
`define OFS_SELFTEST 4'h4

// field positions
`define BURST_MSB 14
`define BURST_LSB 12
`define BASE_LSB 5
`define EE_SW_EN_BIT 4
`define EE_DI_BIT 3
`define ST_TX_DONE_BIT 12
`define ST_TX_FAIL_BIT 11
`define ST_RX_DONE_BIT 4
`define ST_RX_FAIL_BIT 3
`define EE_CFG_SPEED_BIT 1

// encodings
`define BURST_SINGLE 3'h0
`define BURST_4 3'h3
`define BURST_8 3'h5
`define BURST_16 3'h7
`define SPEED_125 2'h0
`define SPEED_62 2'h1
`define SPEED_41 2'h2
`define SPEED_25 2'h3
`define DIV_125 3'h1
`define DIV_62 3'h2
`define DIV_41 3'h3
`define DIV_25 3'h5

// reset values
`define BASE_ADDR_RESET 16'h0300
`define BANK_SEL_RESET 6'h00
`define BURST_RESET 3'h0
`define SPEED_RESET 2'h0

// eeprom word map and serial read command
`define EE_WORD_BASE 3'h0
`define EE_WORD_STN_LOW 3'h1
`define EE_WORD_STN_MID 3'h2
`define EE_WORD_STN_HIGH 3'h3
`define EE_WORD_CONFIG 3'h6
`define EE_LAST_WORD 3'h6
`define EE_READ_CMD 6'h30
`define EE_CMD_BITS 5'h09
`define EE_LAST_BIT 5'h19

// timing
`define CLK_PERIOD_NS 20
`define EE_SK_HALF_NS 500
`define EE_SK_HALF_CYC ((`EE_SK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STRAP_SETTLE 2'h3

`endif

// ---- host_cfg_pkg.sv ----
/*
 * state types of the host configuration bank.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package host_cfg_pkg;

   typedef enum logic [1:0] {TOP_SETTLE, TOP_LOAD, TOP_READY} top_state_t;

   typedef enum logic [1:0] {LD_IDLE, LD_SK_LOW, LD_SK_HIGH, LD_GAP} loader_state_t;

endpackage

// ---- bus_speed_divider.sv ----
/*
 * one-cycle enable pulse at the selected on-chip bus rate.
 * assumes the speed code comes from logic on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "host_cfg_consts.svh"

module bus_speed_divider
   import host_cfg_pkg::*;
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   // control
   input wire logic [1:0] i_speed,
   output logic o_tick
);

   typedef struct packed {
      logic [2:0] cnt;
      logic tick;
   } div_state_t;

   div_state_t r, n;
   logic [2:0] ratio;

   always_comb begin
      unique case (i_speed)
         `SPEED_125: ratio = `DIV_125;
         `SPEED_62: ratio = `DIV_62;
         `SPEED_41: ratio = `DIV_41;
         `SPEED_25: ratio = `DIV_25;
      endcase
      n = r;
      // a new code takes effect at the next reload, so rate changes are glitch free
      if (r.cnt == 3'h0) begin
         n.tick = 1'b1;
         n.cnt = ratio - 3'h1;
      end else begin
         n.tick = 1'b0;
         n.cnt = r.cnt - 3'h1;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign o_tick = r.tick;

endmodule
`default_nettype wire

// ---- eeprom_loader.sv ----
/*
 * serial eeprom reader: fetches words 0 to 6 one read command at a time.
 * assumes a three-wire serial eeprom and a data input already synchronised.
 */
`timescale 1ns/100ps
`default_nettype none
`include "host_cfg_consts.svh"

module eeprom_loader
   import host_cfg_pkg::*;
#(
   parameter int HALF_CYC = `EE_SK_HALF_CYC
)
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   // control
   input wire logic i_start,
   output logic o_done,
   // loaded words
   output logic o_word_valid,
   output logic [2:0] o_word_idx,
   output logic [15:0] o_word_data,
   // serial pins
   input wire logic i_serial_in,
   output logic o_chip_sel,
   output logic o_serial_clk,
   output logic o_serial_out
);

   if (HALF_CYC < 1 || HALF_CYC > 255) begin : g_half_check
      $error("eeprom_loader: HALF_CYC out of range");
   end

   localparam logic [7:0] HALF_RELOAD = 8'(HALF_CYC - 1);

   typedef struct packed {
      loader_state_t st;
      logic [7:0] cnt;
      logic [4:0] bitn;
      logic [2:0] word;
      logic [15:0] sreg;
      logic cs;
      logic sk;
      logic dout;
      logic valid;
      logic done;
      logic [2:0] widx;
   } loader_reg_t;

   loader_reg_t r, n;

   // start bit, read opcode, then the six address bits; zero while data comes back
   function automatic logic cmd_bit(input logic [2:0] word, input logic [4:0] bitn);
      logic [8:0] cmd;
      cmd = {`EE_READ_CMD, word};
      cmd_bit = (bitn < `EE_CMD_BITS) ? cmd[4'(5'h08 - bitn)] : 1'b0;
   endfunction

   always_comb begin
      n = r;
      n.valid = 1'b0;
      n.done = 1'b0;
      n.cnt = (r.cnt == 8'h00) ? HALF_RELOAD : r.cnt - 8'h01;
      unique case (r.st)
         LD_IDLE: begin
            n.cs = 1'b0;
            n.sk = 1'b0;
            if (i_start) begin
               n.st = LD_SK_LOW;
               n.word = `EE_WORD_BASE;
               n.bitn = 5'h00;
               n.cs = 1'b1;
               n.cnt = HALF_RELOAD;
               n.dout = cmd_bit(`EE_WORD_BASE, 5'h00);
            end
         end
         LD_SK_LOW: begin
            if (r.cnt == 8'h00) begin
               n.sk = 1'b1;
               n.st = LD_SK_HIGH;
            end
         end
         LD_SK_HIGH: begin
            if (r.cnt == 8'h00) begin
               n.sk = 1'b0;
               // sampled at the end of the high phase, long after the part drives it
               if (r.bitn >= `EE_CMD_BITS) begin
                  n.sreg = {r.sreg[14:0], i_serial_in};
               end
               if (r.bitn == `EE_LAST_BIT) begin
                  n.cs = 1'b0;
                  n.st = LD_GAP;
               end else begin
                  n.bitn = r.bitn + 5'h01;
                  n.dout = cmd_bit(r.word, r.bitn + 5'h01);
                  n.st = LD_SK_LOW;
               end
            end
         end
         LD_GAP: begin
            if (r.cnt == 8'h00) begin
               n.valid = 1'b1;
               n.widx = r.word;
               if (r.word == `EE_LAST_WORD) begin
                  n.done = 1'b1;
                  n.st = LD_IDLE;
               end else begin
                  n.word = r.word + 3'h1;
                  n.bitn = 5'h00;
                  n.cs = 1'b1;
                  n.dout = cmd_bit(r.word + 3'h1, 5'h00);
                  n.st = LD_SK_LOW;
               end
            end
         end
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         r <= '{st: LD_IDLE, default: '0};
      end else begin
         r <= n;
      end
   end

   assign o_done = r.done;
   assign o_word_valid = r.valid;
   assign o_word_idx = r.widx;
   assign o_word_data = r.sreg;
   assign o_chip_sel = r.cs;
   assign o_serial_clk = r.sk;
   assign o_serial_out = r.dout;

endmodule
`default_nettype wire

// ---- host_cfg_monitor.sv ----
/*
 * port checker for the host configuration bank.
 * assumes binding to host_config_eeprom_regs, one clock domain.
 */
`timescale 1ns/100ps
`default_nettype none
module host_cfg_monitor (
   // host side
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic [3:0] i_host_addr,
   input wire logic i_host_rd,
   input wire logic i_host_wr,
   input wire logic [1:0] i_host_be,
   input wire logic [15:0] i_host_wdata,
   input wire logic [15:0] o_host_rdata,
   input wire logic o_host_rdata_valid,
   // pins and configuration
   input wire logic o_eeprom_chip_sel,
   input wire logic o_eeprom_serial_clk,
   input wire logic o_eeprom_serial_out,
   input wire logic [47:0] o_station_addr,
   input wire logic [2:0] o_burst_len_field,
   input wire logic [4:0] o_burst_beats,
   input wire logic [1:0] o_bus_speed_field,
   input wire logic o_bus_tick,
   input wire logic o_config_busy
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);
   ////////////////////////////////////////////////////////////////////////
   // bank and pin control rebuilt from host writes
   logic [5:0] bank_r;
   logic [4:0] ctrl_r;
   logic [2:0] ofs;
   logic [2:0] pins;
   assign ofs = i_host_addr[3:1];
   assign pins = {o_eeprom_serial_out, o_eeprom_serial_clk, o_eeprom_chip_sel};
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         bank_r <= 6'h00;
         ctrl_r <= 5'h00;
      end else if (i_host_wr && i_host_be[0]) begin
         if (ofs == 3'h7) begin
            bank_r <= i_host_wdata[5:0];
         end else if (bank_r == 6'h03 && ofs == 3'h1) begin
            ctrl_r <= i_host_wdata[4:0];
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   read_answer_a: assert property (o_host_rdata_valid == $past(i_host_rd))
      else $error("read answer not one cycle after request");
   bank1_empty_a: assert property (i_host_rd && !i_host_wr && bank_r == 6'h01 && ofs != 3'h7
      |=> o_host_rdata == 16'h0000) else $error("bank 1 read not zero");
   bank_sel_a: assert property (i_host_rd && !i_host_wr && ofs == 3'h7
      |=> o_host_rdata == {10'h000, $past(bank_r)}) else $error("bank select read wrong");
   burst_beats_a: assert property ($stable(o_burst_len_field) |-> o_burst_beats ==
      ((o_burst_len_field == 3'h3) ? 5'h04 : (o_burst_len_field == 3'h5) ? 5'h08 :
      (o_burst_len_field == 3'h7) ? 5'h10 : 5'h01)) else $error("burst beats wrong");
   station_wr_a: assert property (i_host_wr && bank_r == 6'h02 && ofs == 3'h0 && i_host_be == 2'h3
      && !o_config_busy |=> o_station_addr[15:0] == $past(i_host_wdata)) else $error("station low not written");
   speed_wr_a: assert property (i_host_wr && bank_r == 6'h03 && ofs == 3'h0 && i_host_be[0]
      && !o_config_busy |=> o_bus_speed_field == $past(i_host_wdata[1:0])) else $error("speed not written");
   tick_full_a: assert property (o_bus_tick && $past(o_bus_speed_field) == 2'h0 |=> o_bus_tick)
      else $error("tick missing at full rate");
   tick_slow_a: assert property ((o_bus_speed_field == 2'h3)[*8] ##0 o_bus_tick ##1
      (o_bus_speed_field == 2'h3)[*5] |-> o_bus_tick && !$past(o_bus_tick)) else $error("slow tick period wrong");
   sw_pins_a: assert property ((ctrl_r[4] && $stable(ctrl_r))[*3] |-> pins == ctrl_r[2:0])
      else $error("pins not following control bits");
   pins_hidden_a: assert property ((!ctrl_r[4] && ctrl_r[0] && !o_config_busy)[*3] |-> !o_eeprom_chip_sel)
      else $error("control bits reached pins");
endmodule
`default_nettype wire

// ---- eeprom_model.sv ----
/*
 * serial eeprom answering word reads.
 * assumes select, clock and data from the device pins; words in IMAGE.
 */
`timescale 1ns/100ps
`default_nettype none
module eeprom_model #(
   parameter logic [111:0] IMAGE = '0
) (
   // device pins
   input wire logic i_cs,
   input wire logic i_sk,
   input wire logic i_di,
   output logic o_do
);
   int n;
   logic [5:0] adr;
   initial begin
      n = 0;
      adr = 6'h00;
      o_do = 1'b0;
   end
   // edges 4..9 carry the address, data follows a dummy zero
   always @(posedge i_sk) begin
      if (i_cs) begin
         n = n + 1;
         if (n >= 4 && n <= 9) begin
            adr = {adr[4:0], i_di};
         end
         if (n == 10) begin
            o_do <= 1'b0;
         end else if (n > 10 && n <= 26) begin
            o_do <= IMAGE[16 * adr + 26 - n];
         end
      end
   end
   // released line shows the inverse, not a stale copy
   always @(negedge i_cs) begin
      n = 0;
      o_do <= ~o_do;
   end
endmodule
`default_nettype wire

// ---- tb_host_config_eeprom_regs.sv ----
/*
 * bench for host_config_eeprom_regs: host port tasks and an eeprom model.
 * assumes the monitor and model files are compiled before it.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_host_config_eeprom_regs;
   localparam logic [111:0] IMAGE = {16'h0F02, 16'hFFFF, 16'hFFFF, 16'h0123, 16'h4567, 16'h89AB, 16'h3A5F};
   localparam logic [2:0] CODES [4] = '{3'h0, 3'h3, 3'h5, 3'h7};
   localparam logic [4:0] BEATS [4] = '{5'h01, 5'h04, 5'h08, 5'h10};
   logic clk, rst_n, rd, wr, present, di, cs, sk, dout, valid, tick, busy;
   logic [3:0] addr, st;
   logic [1:0] be, speed;
   logic [15:0] wdata, rdata, base, d;
   logic [47:0] stn;
   logic [2:0] bfield;
   logic [4:0] beats;
   int fail_count, check_count, cyc;

   host_config_eeprom_regs #(.EE_HALF_CYC(4)) dut (
      .i_ref_clk(clk), .i_reset_n(rst_n), .i_host_addr(addr), .i_host_rd(rd),
      .i_host_wr(wr), .i_host_be(be), .i_host_wdata(wdata), .o_host_rdata(rdata),
      .o_host_rdata_valid(valid), .i_eeprom_present_pin(present), .i_eeprom_serial_in(di),
      .o_eeprom_chip_sel(cs), .o_eeprom_serial_clk(sk), .o_eeprom_serial_out(dout),
      .i_tx_selftest_done(st[3]), .i_tx_selftest_failed(st[2]), .i_rx_selftest_done(st[1]),
      .i_rx_selftest_failed(st[0]), .o_base_addr(base), .o_station_addr(stn),
      .o_burst_len_field(bfield), .o_burst_beats(beats), .o_bus_speed_field(speed),
      .o_bus_tick(tick), .o_config_busy(busy));
   eeprom_model #(.IMAGE(IMAGE)) ee (.i_cs(cs), .i_sk(sk), .i_di(dout), .o_do(di));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      check_count++;
      if (s !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] v, input logic [1:0] b);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      be <= b;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input string n, input logic [3:0] a, input logic [15:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
      chk(n, d, e);
   endtask
   task automatic do_reset(input logic p);
      @(posedge clk);
      rst_n <= 1'b0;
      present <= p;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 5000 && busy !== 1'b0; i++) begin
         @(posedge clk);
      end
      chk("busy", {15'h0000, busy}, 16'h0000);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // whole run needs about 1800 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 10000) begin
         fail_count++;
         report_and_stop();
      end
   end
   initial begin
      {rd, wr, addr, be, wdata, st, rst_n} = '0;
      present = 1'b1;
      do_reset(1'b1);
      rd_chk("base", 4'h0, 16'h3A40);
      chk("base out", base, 16'h3A40);
      for (int i = 0; i < 4; i++) begin
         wr_reg(4'h8, {1'b1, CODES[i], 12'hFFF}, 2'h3);
         rd_chk("burst", 4'h8, {1'b0, CODES[i], 12'h000});
         chk("beats", {11'h000, beats}, {11'h000, BEATS[i]});
      end
      wr_reg(4'hE, 16'h0002, 2'h3);
      for (int i = 0; i < 3; i++) begin
         rd_chk("station", 4'(2 * i), IMAGE[16 * i + 16 +: 16]);
         chk("station out", stn[16 * i +: 16], IMAGE[16 * i + 16 +: 16]);
      end
      wr_reg(4'h0, 16'h1234, 2'h3);
      wr_reg(4'h2, 16'hFFFF, 2'h1);
      rd_chk("low", 4'h0, 16'h1234);
      rd_chk("middle", 4'h2, 16'h45FF);
      chk("select pin", {15'h0000, cs}, 16'h0000);
      wr_reg(4'hE, 16'h0001, 2'h3);
      wr_reg(4'h0, 16'hFFFF, 2'h3);
      rd_chk("bank1", 4'h0, 16'h0000);
      rd_chk("bank1", 4'h8, 16'h0000);
      rd_chk("select", 4'hE, 16'h0001);
      wr_reg(4'hE, 16'h0003, 2'h3);
      rd_chk("select", 4'hE, 16'h0003);
      rd_chk("speed", 4'h0, 16'h0003);
      for (int i = 0; i < 4; i++) begin
         wr_reg(4'h0, 16'(i), 2'h3);
         repeat (20) @(posedge clk);
         rd_chk("speed", 4'h0, 16'(i));
      end
      wr_reg(4'h2, 16'h0007, 2'h3);
      repeat (4) @(posedge clk);
      chk("hidden", {14'h0000, sk, cs}, 16'h0000);
      for (int i = 0; i < 8; i++) begin
         wr_reg(4'h2, 16'h0010 | 16'(i), 2'h3);
         repeat (4) @(posedge clk);
         chk("pins", {13'h0000, dout, sk, cs}, 16'(i));
         rd_chk("control", 4'h2, {11'h000, 1'b1, di, 3'(i)});
      end
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         st <= 4'(i);
         rd_chk("selftest", 4'h4, {3'h0, i[3:2], 6'h00, i[1:0], 3'h0});
      end
      do_reset(1'b0);
      rd_chk("base", 4'h0, 16'h0300);
      chk("base out", base, 16'h0300);
      chk("select pin", {15'h0000, cs}, 16'h0000);
      wr_reg(4'hE, 16'h0003, 2'h3);
      rd_chk("speed", 4'h0, 16'h0000);
      report_and_stop();
   end
endmodule
bind host_config_eeprom_regs host_cfg_monitor mon (.*);
`default_nettype wire
